// ### design/cfgm_loader.sv
// Configuration loader and mode control: power-on delay, scheme inputs,
// decryption, run-length expansion, initialization and user mode.
// Assumes all inputs synchronous to core_clk and a register master that
// never overlaps read and write strobes.
//
// Contract
// - User I/O stays tri-stated until user mode.
// - After loading, initialize, enable I/O, enter user.
// - Reconfig pin returns device to command mode.
// - Reset-delay select low 100 ms, high 12 ms.
// - Pull-up control high disables pull-ups before user.
// - Input-level select captured once at power-up only.
// - Full load required after power-up before user.
// - Exactly one of five schemes accepts data.
// - Chain enable out passes to next device.
// - Feature legality depends on scheme and source.
// - Compressed stream expanded in real time.
// - Host loads serial, parallel or virtual location.
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/10ps
module cfgm_loader import cfgm_pkg::*; #(
   parameter int POR_LONG = POR_LONG_CYC,
   parameter int POR_SHORT = POR_SHORT_CYC,
   parameter int CFG_BYTES = 16
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic reset_delay_select,
   input wire logic config_input_level_select,
   input wire logic pullup_disable,
   input wire logic reconfig_n,
   input wire logic chain_config_enable_in_n,
   input wire logic dclk,
   input wire logic [7:0] cfg_data,
   input wire logic jtag_shift,
   input wire logic jtag_tdi,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   output logic as_clk,
   output logic as_cs_n,
   output logic io_oe_allow,
   output logic io_pullup_en,
   output logic user_reset,
   output logic config_done,
   output logic chain_config_enable_out_n,
   output logic level_sel,
   output logic sram_wr,
   output cfgm_sram_wr_t sram_req
);
   localparam logic [15:0] NBYTES = 16'(CFG_BYTES);

   if (POR_LONG < 1 || POR_LONG >= (1 << POR_CW) || POR_SHORT < 1 ||
       POR_SHORT >= (1 << POR_CW) || CFG_BYTES < 1 || CFG_BYTES > 65535)
   begin : g_chk
      $error("cfgm_loader: parameter out of range");
   end

   cfgm_state_t state_r, state_nxt;
   cfgm_ctrl_t ctrl_r, ctrl_nxt;
   cfgm_sram_wr_t wreq_r, wreq_nxt;
   logic por_arm_r, por_arm_nxt, por_done_r, por_done_nxt;
   logic [POR_CW-1:0] por_lim_r, por_lim_nxt, por_cnt_r, por_cnt_nxt;
   logic lvl_r, lvl_nxt, dclk_q_r, dclk_q_nxt, as_clk_r, as_clk_nxt;
   logic as_div_r, as_div_nxt, wr_r, wr_nxt, ferr_r, ferr_nxt;
   logic [7:0] key_r, key_nxt, sh_r, sh_nxt, last_r, last_nxt;
   logic [1:0] fdiv_r, fdiv_nxt;
   logic [2:0] bcnt_r, bcnt_nxt, rep_r, rep_nxt;
   logic [15:0] cnt_r, cnt_nxt, rdata_r, rdata_nxt;
   logic [3:0] init_r, init_nxt;
   logic fok, run;

   // Which optional features a scheme and its data source may use.
   function automatic logic feat_ok(input cfgm_ctrl_t c);
      logic sec;
      sec = c.decrypt_en | c.decomp_en;
      unique case (c.scheme)
         FAST_PARALLEL_PASSIVE_SCHEME: feat_ok = (c.src == SRC_HOST) | !sec;
         ACTIVE_SERIAL_SCHEME: feat_ok = 1'b1;
         PASSIVE_SERIAL_SCHEME:
            feat_ok = !(c.src == SRC_CABLE && c.remote_en);
         PARALLEL_ASYNC_SCHEME: feat_ok = !sec;
         JTAG_SCHEME: feat_ok = !sec && !c.remote_en;
         default: feat_ok = 1'b0;
      endcase
   endfunction : feat_ok

   assign fok = feat_ok(ctrl_r);
   assign run = state_r == ST_CFG && por_done_r && reconfig_n &&
                !chain_config_enable_in_n && fok && cnt_r < NBYTES;

   always_comb begin
      logic bitv, bitd, bytev;
      logic [7:0] byt;
      bitv = 1'b0;
      bitd = 1'b0;
      bytev = 1'b0;
      byt = 8'h00;
      state_nxt = state_r;
      ctrl_nxt = ctrl_r;
      wreq_nxt = wreq_r;
      por_arm_nxt = 1'b1;
      por_done_nxt = por_done_r;
      por_lim_nxt = por_lim_r;
      por_cnt_nxt = por_cnt_r;
      lvl_nxt = lvl_r;
      dclk_q_nxt = dclk;
      as_clk_nxt = as_clk_r;
      as_div_nxt = as_div_r;
      wr_nxt = 1'b0;
      ferr_nxt = state_r == ST_CFG && !fok;
      key_nxt = key_r;
      sh_nxt = sh_r;
      last_nxt = last_r;
      fdiv_nxt = fdiv_r;
      bcnt_nxt = bcnt_r;
      rep_nxt = rep_r;
      cnt_nxt = cnt_r;
      init_nxt = init_r;
      rdata_nxt = 16'h0000;

      // Select and level straps are caught in the first cycle after reset.
      if (!por_arm_r) begin
         por_lim_nxt = reset_delay_select ? POR_CW'(POR_SHORT - 1) :
                       POR_CW'(POR_LONG - 1);
         lvl_nxt = config_input_level_select;
      end else if (!por_done_r) begin
         if (por_cnt_r == por_lim_r) begin
            por_done_nxt = 1'b1;
         end else begin
            por_cnt_nxt = por_cnt_r + 1'b1;
         end
      end

      if (run) begin
         unique case (ctrl_r.scheme)
            FAST_PARALLEL_PASSIVE_SCHEME: begin
               if (dclk && !dclk_q_r) begin
                  byt = cfg_data;
                  if (ctrl_r.decrypt_en || ctrl_r.decomp_en) begin
                     fdiv_nxt = fdiv_r + 2'h1;
                     bytev = fdiv_r == 2'(FPP_SLOW_DCLK - 1);
                  end else begin
                     bytev = 1'b1;
                  end
               end
            end
            ACTIVE_SERIAL_SCHEME: begin
               as_div_nxt = ~as_div_r;
               if (as_div_r == 1'(AS_DIV - 1)) begin
                  as_clk_nxt = ~as_clk_r;
                  bitv = !as_clk_r;
                  bitd = cfg_data[0];
               end
            end
            PASSIVE_SERIAL_SCHEME: begin
               bitv = dclk && !dclk_q_r;
               bitd = cfg_data[0];
            end
            PARALLEL_ASYNC_SCHEME: begin
               bytev = reg_wr && reg_addr == ADR_DATA;
               byt = reg_wdata[7:0];
            end
            JTAG_SCHEME: begin
               bitv = jtag_shift;
               bitd = jtag_tdi;
            end
            default: ;
         endcase
      end
      if (state_r != ST_CFG) begin
         as_clk_nxt = 1'b0;
      end

      // Serial schemes assemble bytes least significant bit first.
      if (bitv) begin
         sh_nxt = {bitd, sh_r[7:1]};
         bcnt_nxt = bcnt_r + 3'h1;
         if (bcnt_r == 3'h7) begin
            bytev = 1'b1;
            byt = {bitd, sh_r[7:1]};
         end
      end
      if (ctrl_r.decrypt_en) begin
         byt = byt ^ key_r;
      end

      // Runs expand at one byte per cycle; the slowed input rate leaves
      // room for the longest run between two incoming bytes.
      if (rep_r != 3'h0) begin
         rep_nxt = rep_r - 3'h1;
         wr_nxt = cnt_r < NBYTES;
         wreq_nxt.data = last_r;
      end else if (bytev) begin
         if (ctrl_r.decomp_en && byt[7:6] == RUN_TAG) begin
            rep_nxt = {1'b0, byt[1:0]} + 3'h1;
         end else begin
            wr_nxt = 1'b1;
            wreq_nxt.data = byt;
            last_nxt = byt;
         end
      end
      if (wr_nxt) begin
         wreq_nxt.addr = cnt_r;
         cnt_nxt = cnt_r + 16'h0001;
      end

      unique case (state_r)
         ST_POR: begin
            if (por_done_r) begin
               state_nxt = ST_CFG;
            end
         end
         ST_CFG: begin
            if (cnt_r == NBYTES && rep_r == 3'h0) begin
               state_nxt = ST_INIT;
               init_nxt = 4'(INIT_CYC - 1);
            end
         end
         ST_INIT: begin
            if (init_r == 4'h0) begin
               state_nxt = ST_USER;
            end else begin
               init_nxt = init_r - 4'h1;
            end
         end
         ST_USER: ;
         default: state_nxt = ST_POR;
      endcase

      if (state_r != ST_POR && !reconfig_n) begin
         state_nxt = ST_CFG;
         cnt_nxt = 16'h0000;
         rep_nxt = 3'h0;
         bcnt_nxt = 3'h0;
         fdiv_nxt = 2'h0;
         wr_nxt = 1'b0;
      end

      if (reg_wr && reg_addr == ADR_CTRL) begin
         ctrl_nxt = cfgm_ctrl_t'(reg_wdata[7:0]);
      end
      if (reg_wr && reg_addr == ADR_KEY) begin
         key_nxt = reg_wdata[7:0];
      end
      if (reg_rd) begin
         unique case (reg_addr)
            ADR_CTRL: rdata_nxt = {8'h00, ctrl_r};
            ADR_KEY: rdata_nxt = {8'h00, key_r};
            ADR_STAT: rdata_nxt = {9'h000, fok, ferr_r, lvl_r,
                                   por_done_r, state_r};
            ADR_CNT: rdata_nxt = cnt_r;
            default: rdata_nxt = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_POR;
         ctrl_r <= cfgm_ctrl_t'(CTRL_RST);
         wreq_r <= '0;
         por_arm_r <= 1'b0;
         por_done_r <= 1'b0;
         por_lim_r <= '0;
         por_cnt_r <= '0;
         lvl_r <= 1'b0;
         dclk_q_r <= 1'b0;
         as_clk_r <= 1'b0;
         as_div_r <= 1'b0;
         wr_r <= 1'b0;
         ferr_r <= 1'b0;
         key_r <= KEY_RST;
         sh_r <= 8'h00;
         last_r <= 8'h00;
         fdiv_r <= 2'h0;
         bcnt_r <= 3'h0;
         rep_r <= 3'h0;
         cnt_r <= 16'h0000;
         init_r <= 4'h0;
         rdata_r <= 16'h0000;
      end else begin
         state_r <= state_nxt;
         ctrl_r <= ctrl_nxt;
         wreq_r <= wreq_nxt;
         por_arm_r <= por_arm_nxt;
         por_done_r <= por_done_nxt;
         por_lim_r <= por_lim_nxt;
         por_cnt_r <= por_cnt_nxt;
         lvl_r <= lvl_nxt;
         dclk_q_r <= dclk_q_nxt;
         as_clk_r <= as_clk_nxt;
         as_div_r <= as_div_nxt;
         wr_r <= wr_nxt;
         ferr_r <= ferr_nxt;
         key_r <= key_nxt;
         sh_r <= sh_nxt;
         last_r <= last_nxt;
         fdiv_r <= fdiv_nxt;
         bcnt_r <= bcnt_nxt;
         rep_r <= rep_nxt;
         cnt_r <= cnt_nxt;
         init_r <= init_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;
   assign as_clk = as_clk_r;
   assign as_cs_n = !(state_r == ST_CFG &&
                      ctrl_r.scheme == ACTIVE_SERIAL_SCHEME);
   assign io_oe_allow = state_r == ST_USER;
   assign io_pullup_en = state_r != ST_USER && !pullup_disable;
   assign user_reset = state_r == ST_INIT;
   assign config_done = state_r == ST_USER;
   assign chain_config_enable_out_n = !(state_r == ST_INIT ||
                                        state_r == ST_USER);
   assign level_sel = lvl_r;
   assign sram_wr = wr_r;
   assign sram_req = wreq_r;

   AST_HIZ: assert property (@(posedge core_clk) disable iff (!rst_n)
      io_oe_allow |-> cnt_r == NBYTES &&
      ($past(state_r) == ST_INIT || $past(state_r) == ST_USER))
      else $error("I/O enabled outside user mode");
   AST_INIT: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(io_oe_allow) |-> $past(state_r) == ST_INIT &&
      $past(user_reset, 8))
      else $error("user mode entered without initialization");
   AST_RECFG: assert property (@(posedge core_clk) disable iff (!rst_n)
      state_r == ST_USER && !reconfig_n |=> state_r == ST_CFG &&
      cnt_r == 16'h0000)
      else $error("reconfig did not return to command mode");
   AST_RESET_DELAY_SELECT: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(por_arm_r) |-> por_lim_r == ($past(reset_delay_select) ?
      POR_CW'(POR_SHORT - 1) : POR_CW'(POR_LONG - 1)))
      else $error("wrong power-on delay selected");
   AST_PORDONE: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(por_done_r) |-> $past(por_cnt_r) == $past(por_lim_r))
      else $error("power-on delay ended early");
   AST_PULL: assert property (@(posedge core_clk) disable iff (!rst_n)
      state_r != ST_USER |-> io_pullup_en == !pullup_disable)
      else $error("pull-up control not followed");
   AST_LVL: assert property (@(posedge core_clk) disable iff (!rst_n)
      por_arm_r && $past(por_arm_r) |-> $stable(level_sel))
      else $error("level select changed after capture");
   AST_LOAD: assert property (@(posedge core_clk) disable iff (!rst_n)
      state_r == ST_INIT |-> cnt_r == NBYTES)
      else $error("initialization before full load");
   AST_NOACC: assert property (@(posedge core_clk) disable iff (!rst_n)
      !por_done_r |-> !sram_wr && chain_config_enable_out_n)
      else $error("activity before power-on delay ended");
   AST_CHAIN: assert property (@(posedge core_clk) disable iff (!rst_n)
      sram_wr |-> !$past(chain_config_enable_in_n, 1) ||
      $past(rep_r) != 3'h0)
      else $error("data accepted while chain enable high");
   AST_FEAT: assert property (@(posedge core_clk) disable iff (!rst_n)
      ferr_r |-> !sram_wr || $past(rep_r) != 3'h0)
      else $error("data accepted with illegal feature set");
endmodule : cfgm_loader

// ### design/cfgm_pkg.sv
// Constants, types and register layout of the configuration loader.
// Assumes a single 10 MHz core clock; no other file is needed.
package cfgm_pkg;
   localparam int CLK_HZ = 10_000_000;
   localparam int POR_LONG_MS = 100;
   localparam int POR_SHORT_MS = 12;
   localparam int POR_LONG_CYC = POR_LONG_MS * (CLK_HZ / 1000);
   localparam int POR_SHORT_CYC = POR_SHORT_MS * (CLK_HZ / 1000);
   localparam int POR_CW = 20;
   localparam int INIT_CYC = 8;
   localparam int AS_DIV = 2;
   localparam int FPP_SLOW_DCLK = 4;

   localparam logic [3:0] ADR_CTRL = 4'h0;
   localparam logic [3:0] ADR_KEY = 4'h1;
   localparam logic [3:0] ADR_DATA = 4'h2;
   localparam logic [3:0] ADR_STAT = 4'h3;
   localparam logic [3:0] ADR_CNT = 4'h4;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] KEY_RST = 8'h00;
   localparam logic [1:0] RUN_TAG = 2'h3;

   typedef enum logic [2:0] {
      FAST_PARALLEL_PASSIVE_SCHEME = 3'h0,
      ACTIVE_SERIAL_SCHEME = 3'h1,
      PASSIVE_SERIAL_SCHEME = 3'h2,
      PARALLEL_ASYNC_SCHEME = 3'h3,
      JTAG_SCHEME = 3'h4
   } cfgm_scheme_t;

   typedef enum logic [1:0] {
      SRC_HOST = 2'h0,
      SRC_CFG_DEVICE = 2'h1,
      SRC_CABLE = 2'h2
   } cfgm_src_t;

   typedef enum logic [2:0] {
      ST_POR = 3'h0,
      ST_CFG = 3'h1,
      ST_INIT = 3'h3,
      ST_USER = 3'h2
   } cfgm_state_t;

   typedef struct packed {
      logic remote_en;
      logic decomp_en;
      logic decrypt_en;
      cfgm_src_t src;
      cfgm_scheme_t scheme;
   } cfgm_ctrl_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] data;
   } cfgm_sram_wr_t;
endpackage : cfgm_pkg

// ### bench/cfgm_host_model.sv
// Host model on the far side of the configuration stream pins.
// Assumes the loader samples dclk on core_clk and takes bit0 for serial.
`timescale 1ns/10ps
module cfgm_host_model (
   input wire logic core_clk,
   input wire logic as_clk,
   output logic dclk,
   output logic [7:0] cfg_data
);
   initial begin
      dclk = 1'b0;
      cfg_data = 8'hA5;
   end

   // The clock stands low between pulses; released data shows its inverse
   // so a late sample cannot pass by chance.
   task automatic pulse(input logic [7:0] d);
      @(posedge core_clk);
      cfg_data <= d;
      @(posedge core_clk);
      dclk <= 1'b1;
      @(posedge core_clk);
      dclk <= 1'b0;
      @(posedge core_clk);
      cfg_data <= ~d;
   endtask : pulse

   task automatic send_byte(input logic [7:0] b, input logic ser);
      if (ser) begin
         for (int i = 0; i < 8; i++) begin
            pulse({7'h00, b[i]});
         end
      end else begin
         pulse(b);
      end
   endtask : send_byte

   // Active serial: each bit stands before the as_clk rise that takes it
   // and changes only after the next fall; ok drops when as_clk stalls.
   task automatic as_send(input logic [7:0] b, output logic ok);
      int n;
      ok = 1'b1;
      for (int i = 0; i < 8; i++) begin
         cfg_data <= {7'h00, b[i]};
         n = 0;
         while (as_clk !== 1'b1 && n < 8) begin
            @(posedge core_clk);
            #1;
            n++;
         end
         if (as_clk !== 1'b1)
            ok = 1'b0;
         while (as_clk !== 1'b0 && n < 16) begin
            @(posedge core_clk);
            #1;
            n++;
         end
         if (as_clk !== 1'b0)
            ok = 1'b0;
      end
   endtask : as_send
endmodule : cfgm_host_model

// ### bench/cfgm_loader_tb_top.sv
// Self-checking bench of the configuration loader.
// Assumes the loader and the host model are compiled before this file.
`timescale 1ns/10ps
module cfgm_loader_tb_top import cfgm_pkg::*; ;
   localparam int P_LONG = 20;
   localparam int P_SHORT = 5;
   localparam int N_BYTES = 4;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic reset_delay_select = 1'b0;
   logic config_input_level_select = 1'b1;
   logic pullup_disable = 1'b1;
   logic reconfig_n = 1'b1;
   logic chain_in_n = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic jtag_shift = 1'b0;
   logic jtag_tdi = 1'b0;
   logic as_ok;
   logic [7:0] jb;
   logic [15:0] reg_rdata, rd;
   logic dclk, as_clk, as_cs_n, io_oe_allow, io_pullup_en, user_reset;
   logic config_done, chain_out_n, level_sel, sram_wr;
   logic [7:0] cfg_data;
   cfgm_sram_wr_t sram_req;
   logic [23:0] exp_q[$];
   int error_cnt = 0;
   int total_checks = 0;
   int init_cnt = 0;
   // Control value beside whether the feature mix is legal.
   logic [8:0] rows [10] = '{{8'hE0, 1'b1}, {8'h28, 1'b0}, {8'h88, 1'b1},
      {8'hE9, 1'b1}, {8'h92, 1'b0}, {8'h72, 1'b1}, {8'h83, 1'b1},
      {8'h43, 1'b0}, {8'h94, 1'b0}, {8'h14, 1'b1}};

   always #50 core_clk = ~core_clk;

   cfgm_loader #(.POR_LONG(P_LONG), .POR_SHORT(P_SHORT),
      .CFG_BYTES(N_BYTES)) uut (.core_clk(core_clk), .rst_n(rst_n),
      .reset_delay_select(reset_delay_select),
      .config_input_level_select(config_input_level_select),
      .pullup_disable(pullup_disable), .reconfig_n(reconfig_n),
      .chain_config_enable_in_n(chain_in_n), .dclk(dclk),
      .cfg_data(cfg_data), .jtag_shift(jtag_shift), .jtag_tdi(jtag_tdi),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .as_clk(as_clk),
      .as_cs_n(as_cs_n), .io_oe_allow(io_oe_allow),
      .io_pullup_en(io_pullup_en), .user_reset(user_reset),
      .config_done(config_done), .chain_config_enable_out_n(chain_out_n),
      .level_sel(level_sel), .sram_wr(sram_wr), .sram_req(sram_req));

   cfgm_host_model host (.core_clk(core_clk), .as_clk(as_clk),
      .dclk(dclk), .cfg_data(cfg_data));

   task automatic check_val(input string nm, input logic [23:0] e,
         input logic [23:0] g);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : check_val

   task automatic check_bit(input string nm, input logic e, input logic g);
      check_val(nm, {23'h0, e}, {23'h0, g});
   endtask : check_bit

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : tally_and_finish

   task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : reg_read

   // Every stream byte must land in order; strays count as mismatches.
   always @(posedge core_clk) begin
      if (user_reset === 1'b1)
         init_cnt++;
      if (sram_wr === 1'b1) begin
         if (exp_q.size() == 0)
            check_val("sram_extra", 24'h0, sram_req);
         else
            check_val("sram_req", exp_q.pop_front(), sram_req);
      end
   end

   // Active serial is selected early so that as_cs_n marks entry to CFG.
   task automatic por_run(input logic sel, input int lim);
      int n;
      reset_delay_select <= sel;
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      check_bit("oe_reset", 1'b0, io_oe_allow);
      check_bit("chain_reset", 1'b1, chain_out_n);
      rst_n <= 1'b1;
      reg_write(ADR_CTRL, 16'h0001);
      n = 2;
      while (as_cs_n !== 1'b0 && n < 60) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      check_bit("por_time", 1'b1, n >= lim && n <= lim + 3);
      check_bit("done_early", 1'b0, config_done);
      check_bit("pull_off_cfg", 1'b0, io_pullup_en);
      $display("power-up test done, delay %0d", n);
      if (n >= 60)
         tally_and_finish();
   endtask : por_run

   task automatic reconfig();
      @(posedge core_clk);
      reconfig_n <= 1'b0;
      @(posedge core_clk);
      reconfig_n <= 1'b1;
      #1;
      check_bit("cmd_mode", 1'b0, config_done);
      check_bit("io_off", 1'b0, io_oe_allow);
      init_cnt = 0;
   endtask : reconfig

   task automatic wait_done(input string nm);
      int i;
      i = 0;
      while (config_done !== 1'b1 && i < 500) begin
         @(posedge core_clk);
         #1;
         i++;
      end
      if (i >= 500) begin
         check_bit(nm, 1'b1, 1'b0);
         tally_and_finish();
      end else begin
         check_val("init_len", 24'(INIT_CYC), 24'(init_cnt));
         check_bit("io_on", 1'b1, io_oe_allow);
         check_bit("pull_user", 1'b0, io_pullup_en);
         check_bit("chain_out", 1'b0, chain_out_n);
         check_val("left", 24'h0, 24'(exp_q.size()));
         $display("%s load done", nm);
      end
   endtask : wait_done

   initial begin
      por_run(1'b0, P_LONG);
      por_run(1'b1, P_SHORT);
      config_input_level_select <= 1'b0;
      reg_write(ADR_CTRL, 16'h0000);
      host.send_byte(8'h3C, 1'b0);
      reg_read(ADR_CNT, rd);
      check_val("chain_drop", 24'h0, {8'h00, rd});
      foreach (rows[k]) begin
         reg_write(ADR_CTRL, {8'h00, rows[k][8:1]});
         reg_read(ADR_CTRL, rd);
         check_val("ctrl_rb", {16'h0, rows[k][8:1]}, {8'h00, rd});
         reg_read(ADR_STAT, rd);
         check_bit("legal", rows[k][0], rd[6]);
      end
      $display("feature table done");
      reg_write(ADR_CTRL, 16'h0000);
      chain_in_n <= 1'b0;
      pullup_disable <= 1'b0;
      @(posedge core_clk);
      #1;
      check_bit("pull_on_cfg", 1'b1, io_pullup_en);
      for (int i = 0; i < N_BYTES; i++) begin
         exp_q.push_back({16'(i), 8'(8'hA0 + i)});
         host.send_byte(8'(8'hA0 + i), 1'b0);
      end
      wait_done("parallel");
      reg_write(ADR_CTRL, 16'h0062);
      reg_write(ADR_KEY, 16'h005A);
      reconfig();
      exp_q = '{{16'h0, 8'h12}, {16'h1, 8'h12}, {16'h2, 8'h12},
         {16'h3, 8'h34}};
      host.send_byte(8'h12 ^ 8'h5A, 1'b1);
      host.send_byte(8'hC1 ^ 8'h5A, 1'b1);
      host.send_byte(8'h34 ^ 8'h5A, 1'b1);
      wait_done("serial");
      reg_write(ADR_CTRL, 16'h0083);
      reconfig();
      host.send_byte(8'h77, 1'b0);
      for (int i = 0; i < N_BYTES; i++) begin
         exp_q.push_back({16'(i), 8'(8'h50 + i)});
         reg_write(ADR_DATA, 16'(8'h50 + i));
      end
      wait_done("memory");
      reg_write(ADR_CTRL, 16'h0020);
      reconfig();
      for (int i = 0; i < N_BYTES; i++) begin
         exp_q.push_back({16'(i), 8'(8'hD0 + i)});
         repeat (4) host.send_byte(8'(8'hD0 + i) ^ 8'h5A, 1'b0);
      end
      wait_done("fast4x");
      reg_write(ADR_CTRL, 16'h0009);
      reconfig();
      for (int i = 0; i < N_BYTES; i++) begin
         exp_q.push_back({16'(i), 8'(8'h60 + i)});
         host.as_send(8'(8'h60 + i), as_ok);
         check_bit("as_clk", 1'b1, as_ok);
      end
      wait_done("active");
      reg_write(ADR_CTRL, 16'h0004);
      reconfig();
      for (int i = 0; i < N_BYTES; i++) begin
         exp_q.push_back({16'(i), 8'(8'h70 + i)});
         jb = 8'(8'h70 + i);
         for (int k = 0; k < 8; k++) begin
            jtag_shift <= 1'b1;
            jtag_tdi <= jb[k];
            @(posedge core_clk);
         end
      end
      jtag_shift <= 1'b0;
      wait_done("jtag");
      reg_write(ADR_STAT, 16'hFFFF);
      reg_read(ADR_STAT, rd);
      check_val("stat_state", 24'h2, {21'h0, rd[2:0]});
      check_bit("stat_level", 1'b1, rd[4]);
      check_bit("level_kept", 1'b1, level_sel);
      reg_read(4'hF, rd);
      check_val("unmapped", 24'h0, {8'h00, rd});
      $display("register test done");
      tally_and_finish();
   end
endmodule : cfgm_loader_tb_top
